// File: hdl/pcr_power_map.vh
// constants for the power configuration register bank
// assumes a 100 MHz system clock and 8-bit index/data access
`ifndef PCR_POWER_MAP_VH
`define PCR_POWER_MAP_VH
// configuration indexes
`define PCR_IDX_PWR_CTRL 8'h06
`define PCR_IDX_OPTIONS 8'h07
`define PCR_IDX_DEV_ID 8'h08
// power control fields
`define PCR_PC_DRIVE_FLOAT 0
`define PCR_PC_DISK_FLOAT 1
`define PCR_PC_SERIAL_FLOAT 2
`define PCR_PC_DMA_CFG 3
`define PCR_PC_PIN_SEL 4
`define PCR_PC_LOCK 5
`define PCR_PC_PAR_FLOAT 6
`define PCR_PC_RSVD 7
// option fields
`define PCR_OP_CLK_DOUBLE 0
`define PCR_OP_FAST_RATE 1
`define PCR_OP_TIMEOUT_IRQ 2
`define PCR_OP_MIDI1 3
`define PCR_OP_MIDI2 4
`define PCR_OP_PD_STAT 5
`define PCR_OP_IDLE_STAT 6
`define PCR_OP_IDLE_MASK 7
// reset values and writable masks
`define PCR_PWR_CTRL_RST 8'h00
`define PCR_OPTIONS_RST 8'h00
`define PCR_PWR_CTRL_WMASK 8'h7f
`define PCR_OPTIONS_WMASK 8'h9f
// arbitrary neutral identification value
`define PCR_DEV_ID_VALUE 8'h5a
// oscillator settling: 8 ms at 10 ns per cycle
`define PCR_SETTLE_MS 8
`define PCR_CLK_PERIOD_NS 10
`define PCR_SETTLE_CYCLES ((`PCR_SETTLE_MS * 1000000) / `PCR_CLK_PERIOD_NS)
// baud prescaler divisors
`define PCR_DIV_STD 4'hd
`define PCR_DIV_MIDI 4'hc
`endif

// File: hdl/pcr_prescaler.v
// one baud-rate prescaler: divides the master clock by 13 or 12
// assumes the selector is quasi-static; a change applies at once to the period already running
`timescale 1ns/10ps
`include "pcr_power_map.vh"
module pcr_prescaler
(
   // clock and reset
   input wire i_clk,
   input wire i_rst_n,
   // control
   input wire i_run,
   input wire i_midi,
   // output
   output reg o_tick
);
   reg [3:0] count;
   wire [3:0] limit;

   assign limit = i_midi ? (`PCR_DIV_MIDI - 4'h1) : (`PCR_DIV_STD - 4'h1);

   // counter wraps at divisor minus one; stopped clock holds it at zero
   always @(posedge i_clk)
   begin
      if (!i_rst_n || !i_run)
      begin
         count <= 4'h0;
         o_tick <= 1'b0;
      end
      else if (count >= limit)
      begin
         count <= 4'h0;
         o_tick <= 1'b1;
      end
      else
      begin
         count <= count + 4'h1;
         o_tick <= 1'b0;
      end
   end
endmodule

// File: hdl/pcr_power_regs.v
// power management, option and identification configuration registers
// assumes the index/data pair decoder delivers index, write and read strobes
// assumes function status and pin signals are synchronous to i_clk
// assumes the strap pin is steady while reset is held
`timescale 1ns/10ps
`include "pcr_power_map.vh"
// Operation
// R1: power control register clears on reset
// R2: drive selects float, data bit7 blocked
// R3: disk outputs float, inputs blocked except change
// R4: idle serial floats, inputs read as one
// R5: dma disabled: ack one, request floated
// R6: pin select: motor/select or idle/powerdown
// R7: sticky lock protects listed bits from writes
// R8: parallel floats, inputs read fixed values
// R9: software preserves reserved bit seven
// R10: option register resets to 0XX0000X
// R11: strap latched; functions clocked undivided/halved
// R12: fast rate bit selects 48 MHz clocking
// R13: timeout interrupt masked unless enabled
// R14: serial prescalers divide by 13 or 12
// R15: powerdown status bit reads live state
// R16: idle status bit reads live state
// R17: idle mask forces idle pin low
// R18: read-only identification register at index 08h
// R19: clocked functions stop clocks, others blocked
// R20: four chip power-down modes supported
// R21: hold master-request clear while oscillator settles
// R22: locked writes complete, protected bits unchanged
module pcr_power_regs
#(
   parameter SETTLE_CYCLES = `PCR_SETTLE_CYCLES
)
(
   // clock and reset
   input wire i_clk,
   input wire i_rst_n,
   // configuration access
   input wire [7:0] i_index,
   input wire [7:0] i_wdata,
   input wire i_wr,
   input wire i_rd,
   output reg [7:0] o_rdata,
   output wire o_lock_active,
   // strap
   input wire i_clock_double_strap,
   // function status
   input wire i_drive_enabled,
   input wire i_parallel_enabled,
   input wire i_chip_powerdown,
   input wire i_disk_powered_down,
   input wire i_disk_idle,
   input wire i_serial1_powered_down,
   input wire i_serial2_powered_down,
   input wire i_ecp_enabled,
   input wire i_osc_stop_req,
   input wire i_pins_float_req,
   input wire i_timeout_irq,
   input wire i_disk_master_req,
   // raw pins in
   input wire i_drive_data_bit7_in,
   input wire [7:0] i_disk_in,
   input wire i_disk_change_in,
   input wire [1:0] i_serial_in,
   input wire [1:0] i_cts_in,
   input wire [1:0] i_dsr_in,
   input wire [1:0] i_carrier_detect_in,
   input wire [1:0] i_ring_indicator_in,
   input wire i_busy_in,
   input wire i_paper_end_in,
   input wire i_printer_select_in,
   input wire i_ack_in,
   input wire i_error_in,
   input wire i_parallel_dma_ack,
   input wire i_motor_one_out,
   input wire i_drive_select_one_out,
   // gated inputs to functions
   output wire o_drive_data_bit7,
   output wire [7:0] o_disk_in,
   output wire o_disk_change,
   output wire [1:0] o_serial_in,
   output wire [1:0] o_cts,
   output wire [1:0] o_dsr,
   output wire [1:0] o_carrier_detect,
   output wire [1:0] o_ring_indicator,
   output wire o_busy,
   output wire o_paper_end,
   output wire o_printer_select,
   output wire o_ack,
   output wire o_error,
   output wire o_parallel_dma_ack,
   // output enables, low while driven, and the dma configurable flag
   output wire o_drive_cs_oe_n,
   output wire o_disk_oe_n,
   output wire [1:0] o_serial_oe_n,
   output wire o_parallel_oe_n,
   output wire o_parallel_dma_req_oe_n,
   output wire o_dma_configurable,
   // shared pins
   output wire o_shared_port_mux,
   output wire o_shared_pin_a,
   output wire o_shared_pin_b,
   // clocking
   output wire o_osc_run,
   output wire o_func_clk_div2,
   output wire o_disk_clk_div2,
   output wire o_fast_rate_ok,
   output wire o_disk_clk_run,
   output wire [1:0] o_serial_clk_run,
   output wire o_ecp_clk_run,
   output wire [1:0] o_baud_tick,
   // interrupt and master request
   output wire o_timeout_irq,
   output wire o_disk_master_req,
   output wire o_settling
);
   reg [7:0] pwr_ctrl;
   reg [7:0] options;
   reg [23:0] settle_count;
   reg osc_stopped;
   wire wr_pwr;
   wire wr_opt;
   wire [7:0] pwr_wmask;
   wire [7:0] opt_wmask;
   wire drive_idle;
   wire par_idle;
   wire idle_pin;
   wire [7:0] opt_view;
   wire [1:0] serial_pd;

   // lock level and write decodes
   assign o_lock_active = pwr_ctrl[`PCR_PC_LOCK];
   assign wr_pwr = i_wr && (i_index == `PCR_IDX_PWR_CTRL);
   assign wr_opt = i_wr && (i_index == `PCR_IDX_OPTIONS);

   // lock removes bits from write masks; write itself still completes
   assign pwr_wmask = `PCR_PWR_CTRL_WMASK &
      ~({7'h00, o_lock_active} << `PCR_PC_LOCK); // [R7] [R22]
   assign opt_wmask = `PCR_OPTIONS_WMASK &
      ~({7'h00, o_lock_active} << `PCR_OP_CLK_DOUBLE); // [R7] [R22]

   // power control register; lock bit can only be set by software
   // the lock bit is itself in the protected set, which makes it sticky
   always @(posedge i_clk)
   begin
      if (!i_rst_n)
         pwr_ctrl <= `PCR_PWR_CTRL_RST; // [R1]
      else if (wr_pwr)
         pwr_ctrl <= (pwr_ctrl & ~pwr_wmask) | (i_wdata & pwr_wmask); // [R7]
   end

   // option register; strap follows its pin for as long as reset is held
   always @(posedge i_clk)
   begin
      if (!i_rst_n)
      begin
         // reset pattern has bit 0 clear, so the strap can simply be or-ed in
         options <= `PCR_OPTIONS_RST | {7'h00, i_clock_double_strap}; // [R10] [R11]
      end
      else if (wr_opt)
      begin
         // status bits are not stored, so their mask bits are clear
         options <= (options & ~opt_wmask) | (i_wdata & opt_wmask); // [R22]
      end
   end

   // status bits are live, not stored, so reads never lag the controller
   assign opt_view = {options[`PCR_OP_IDLE_MASK], // [R17]
      i_disk_idle, // [R16]
      i_disk_powered_down, // [R15]
      options[4:0]}; // [R10]

   // read mux; unmapped indexes belong to other banks and read zero
   always @*
   begin
      o_rdata = 8'h00;
      if (i_rd)
      begin
         case (i_index)
            `PCR_IDX_PWR_CTRL: o_rdata = pwr_ctrl; // [R9]
            `PCR_IDX_OPTIONS: o_rdata = opt_view;
            `PCR_IDX_DEV_ID: o_rdata = `PCR_DEV_ID_VALUE; // [R18]
            default: o_rdata = 8'h00;
         endcase
      end
   end

   // drive interface: unclocked, powered down by blocking access
   // blocked bit7 reads zero; the drive function must not rely on it
   assign drive_idle = !i_drive_enabled || i_chip_powerdown;
   assign o_drive_cs_oe_n = pwr_ctrl[`PCR_PC_DRIVE_FLOAT] && drive_idle; // [R2] [R19]
   assign o_drive_data_bit7 = o_drive_cs_oe_n ? 1'b0 : i_drive_data_bit7_in; // [R2]

   // disk controller float and input block, disk change passes
   // interrupt, idle and powerdown pins stay driven, so none is gated here
   assign o_disk_oe_n = pwr_ctrl[`PCR_PC_DISK_FLOAT] && i_disk_powered_down; // [R3]
   assign o_disk_in = o_disk_oe_n ? 8'h00 : i_disk_in; // [R3]
   assign o_disk_change = i_disk_change_in; // [R3]

   // per-port power-down, port 1 in bit 0
   assign serial_pd = {i_serial2_powered_down, i_serial1_powered_down};

   // serial ports float individually, blocked inputs read one
   // interrupt lines are not part of this gating and stay driven
   assign o_serial_oe_n = {2{pwr_ctrl[`PCR_PC_SERIAL_FLOAT]}} & serial_pd; // [R4]
   assign o_serial_in = i_serial_in | o_serial_oe_n; // [R4]
   assign o_cts = i_cts_in | o_serial_oe_n; // [R4]
   assign o_dsr = i_dsr_in | o_serial_oe_n; // [R4]
   assign o_carrier_detect = i_carrier_detect_in | o_serial_oe_n; // [R4]
   assign o_ring_indicator = i_ring_indicator_in | o_serial_oe_n; // [R4]

   // parallel port float with fixed blocked input values
   // both parallel interrupts stay driven while the rest floats
   assign par_idle = !i_parallel_enabled || i_chip_powerdown;
   assign o_parallel_oe_n = pwr_ctrl[`PCR_PC_PAR_FLOAT] && par_idle; // [R8] [R19]
   assign o_busy = o_parallel_oe_n ? 1'b1 : i_busy_in; // [R8]
   assign o_paper_end = o_parallel_oe_n ? 1'b0 : i_paper_end_in; // [R8]
   assign o_printer_select = o_parallel_oe_n ? 1'b0 : i_printer_select_in; // [R8]
   assign o_ack = o_parallel_oe_n ? 1'b1 : i_ack_in; // [R8]
   assign o_error = o_parallel_oe_n ? 1'b1 : i_error_in; // [R8]

   // dma only configurable when enabled here
   // the request also floats along with the other parallel pins
   assign o_dma_configurable = pwr_ctrl[`PCR_PC_DMA_CFG]; // [R5]
   assign o_parallel_dma_ack = o_dma_configurable ? i_parallel_dma_ack : 1'b1; // [R5]
   assign o_parallel_dma_req_oe_n = !o_dma_configurable || o_parallel_oe_n; // [R5]

   // shared pins: motor/select or idle/powerdown status
   assign o_shared_port_mux = pwr_ctrl[`PCR_PC_PIN_SEL];
   assign idle_pin = options[`PCR_OP_IDLE_MASK] ? 1'b0 : i_disk_idle; // [R17]
   assign o_shared_pin_a = o_shared_port_mux ? idle_pin : i_motor_one_out; // [R6]
   assign o_shared_pin_b = o_shared_port_mux ? i_disk_powered_down :
      i_drive_select_one_out; // [R6]

   // clock division choices
   // disk clock is halved only while the fast rate is off
   assign o_func_clk_div2 = options[`PCR_OP_CLK_DOUBLE]; // [R11]
   assign o_fast_rate_ok = options[`PCR_OP_FAST_RATE] &&
      options[`PCR_OP_CLK_DOUBLE]; // [R12]
   assign o_disk_clk_div2 = options[`PCR_OP_CLK_DOUBLE] && !o_fast_rate_ok; // [R12]

   // chip modes: oscillator request and pin float request are independent
   // running oscillator with pins floated is the fast wake-up mode
   assign o_osc_run = !(i_chip_powerdown && i_osc_stop_req); // [R20]
   assign o_disk_clk_run = o_osc_run && !i_disk_powered_down &&
      !(i_chip_powerdown && i_pins_float_req); // [R19] [R20]
   assign o_serial_clk_run = {2{o_osc_run && !i_chip_powerdown}} &
      ~serial_pd; // [R19]
   assign o_ecp_clk_run = o_osc_run && i_ecp_enabled && !i_chip_powerdown; // [R19]

   // timeout interrupt gate
   // gate only; the choice of interrupt line lives in the parallel port
   assign o_timeout_irq = options[`PCR_OP_TIMEOUT_IRQ] && i_timeout_irq; // [R13]

   // settling counter after oscillator restart; sized for 800000 cycles
   // 24 bits reach 16777215 cycles; longer settle times need a wider counter
   always @(posedge i_clk)
   begin
      if (!i_rst_n)
      begin
         osc_stopped <= 1'b0;
         settle_count <= 24'h000000;
      end
      else
      begin
         osc_stopped <= !o_osc_run;
         if (!o_osc_run)
            settle_count <= 24'h000000;
         else if (osc_stopped)
            settle_count <= SETTLE_CYCLES[23:0]; // [R21]
         else if (settle_count != 24'h000000)
            settle_count <= settle_count - 24'h000001;
      end
   end

   // settling also covers the edge on which the oscillator restarts, so the
   // master request cannot slip out before the counter is loaded
   assign o_settling = (settle_count != 24'h000000) || !o_osc_run || osc_stopped; // [R21]

   // master request held low until the oscillator has settled
   assign o_disk_master_req = i_disk_master_req && !o_settling; // [R21]

   // baud prescalers for both serial ports
   // a stopped port restarts its prescaler from zero when woken
   pcr_prescaler u_pre1
   (
      .i_clk(i_clk),
      .i_rst_n(i_rst_n),
      .i_run(o_serial_clk_run[0]),
      .i_midi(options[`PCR_OP_MIDI1]), // [R14]
      .o_tick(o_baud_tick[0])
   );

   pcr_prescaler u_pre2
   (
      .i_clk(i_clk),
      .i_rst_n(i_rst_n),
      .i_run(o_serial_clk_run[1]),
      .i_midi(options[`PCR_OP_MIDI2]), // [R14]
      .o_tick(o_baud_tick[1])
   );
endmodule

// File: bench/pcr_regs_checker.sv
// concurrent checks on the power configuration register bank
// assumes a bind from tb_top; port names match the design top
`timescale 1ns/10ps
`include "pcr_power_map.vh"
module pcr_regs_checker
(
   // clock and access
   input logic i_clk,
   input logic i_rst_n,
   input logic [7:0] i_index,
   input logic [7:0] i_wdata,
   input logic i_wr,
   input logic i_rd,
   input logic [7:0] o_rdata,
   input logic o_lock_active,
   // status and raw pins
   input logic i_drive_enabled,
   input logic i_serial1_powered_down,
   input logic i_disk_idle,
   input logic i_disk_powered_down,
   input logic i_motor_one_out,
   input logic i_drive_select_one_out,
   // gated outputs
   input logic o_drive_cs_oe_n,
   input logic o_drive_data_bit7,
   input logic [1:0] o_serial_oe_n,
   input logic [1:0] o_serial_in,
   input logic o_parallel_dma_ack,
   input logic o_parallel_dma_req_oe_n,
   input logic o_shared_port_mux,
   input logic o_shared_pin_a,
   input logic o_shared_pin_b
);
   // one domain, so clock and reset are given once
   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_rst_n);
   sequence s_rd_pc; i_rd && i_index == `PCR_IDX_PWR_CTRL; endsequence
   sequence s_wr_pc; i_wr && i_index == `PCR_IDX_PWR_CTRL && !o_lock_active; endsequence
   property p_lock_hold; o_lock_active |=> o_lock_active; endproperty
   a_lock_hold: assert property (p_lock_hold)
      else $error("lock dropped without reset");
   property p_lock_set; s_wr_pc |=> o_lock_active == $past(i_wdata[5]); endproperty
   a_lock_set: assert property (p_lock_set)
      else $error("lock bit not written");
   property p_drv; s_rd_pc ##0 (o_rdata[0] && !i_drive_enabled)
      |-> o_drive_cs_oe_n && !o_drive_data_bit7; endproperty
   a_drv: assert property (p_drv)
      else $error("drive pins not floated");
   property p_ser; s_rd_pc ##0 (o_rdata[2] && i_serial1_powered_down)
      |-> o_serial_oe_n[0] && o_serial_in[0]; endproperty
   a_ser: assert property (p_ser)
      else $error("serial pins not floated");
   property p_dma; s_rd_pc ##0 !o_rdata[3]
      |-> o_parallel_dma_ack && o_parallel_dma_req_oe_n; endproperty
   a_dma: assert property (p_dma)
      else $error("dma pins not parked");
   property p_mux; !o_shared_port_mux |-> o_shared_pin_a == i_motor_one_out
      && o_shared_pin_b == i_drive_select_one_out; endproperty
   a_mux: assert property (p_mux)
      else $error("shared pins wrong source");
   property p_id; i_rd && i_index == `PCR_IDX_DEV_ID |-> o_rdata == `PCR_DEV_ID_VALUE; endproperty
   a_id: assert property (p_id)
      else $error("identification value wrong");
   property p_stat; i_rd && i_index == `PCR_IDX_OPTIONS
      |-> o_rdata[6:5] == {i_disk_idle, i_disk_powered_down}; endproperty
   a_stat: assert property (p_stat)
      else $error("status bits not live");
   property p_idle; i_rd && i_index == `PCR_IDX_OPTIONS ##0 (o_rdata[7] && o_shared_port_mux)
      |-> !o_shared_pin_a; endproperty
   a_idle: assert property (p_idle)
      else $error("masked idle pin not low");
endmodule

// File: bench/tb_top.sv
// self-checking bench for the power configuration register bank
// assumes the design header on the include path; settle count cut to 20
`timescale 1ns/10ps
`include "pcr_power_map.vh"
module tb_top;
   logic i_clk = 0, i_rst_n = 0, i_wr = 0, i_rd = 0, i_clock_double_strap = 1;
   logic [7:0] i_index = 0, i_wdata = 0, i_disk_in = 8'h3c;
   logic i_drive_enabled = 1, i_parallel_enabled = 1, i_chip_powerdown = 0;
   logic i_disk_powered_down = 0, i_disk_idle = 0, i_serial1_powered_down = 0;
   logic i_serial2_powered_down = 0, i_ecp_enabled = 1, i_osc_stop_req = 0;
   logic i_pins_float_req = 0, i_timeout_irq = 0, i_disk_master_req = 1;
   logic i_drive_data_bit7_in = 1, i_disk_change_in = 0, i_busy_in = 0, i_paper_end_in = 1;
   logic i_printer_select_in = 1, i_ack_in = 0, i_error_in = 0, i_parallel_dma_ack = 0;
   logic i_motor_one_out = 1, i_drive_select_one_out = 0;
   logic [1:0] i_serial_in = 0, i_cts_in = 0, i_dsr_in = 0;
   logic [1:0] i_carrier_detect_in = 0, i_ring_indicator_in = 0;
   logic [7:0] o_rdata, o_disk_in;
   logic [1:0] o_serial_in, o_cts, o_dsr, o_carrier_detect, o_ring_indicator;
   logic [1:0] o_serial_oe_n, o_serial_clk_run, o_baud_tick;
   logic o_lock_active, o_drive_data_bit7, o_disk_change, o_busy, o_paper_end;
   logic o_printer_select, o_ack, o_error, o_parallel_dma_ack, o_drive_cs_oe_n;
   logic o_disk_oe_n, o_parallel_oe_n, o_parallel_dma_req_oe_n, o_dma_configurable;
   logic o_shared_port_mux, o_shared_pin_a, o_shared_pin_b, o_osc_run, o_func_clk_div2;
   logic o_disk_clk_div2, o_fast_rate_ok, o_disk_clk_run, o_ecp_clk_run;
   logic o_timeout_irq, o_disk_master_req, o_settling;
   int error_cnt = 0, n_checks = 0, cyc = 0;
   // short settle count keeps the wake-up scenario brief
   pcr_power_regs #(.SETTLE_CYCLES(20)) uut (.*);
   // 100 MHz clock
   initial forever #5 i_clk = ~i_clk;
   task automatic finish_test();
      $display("checks %0d errors %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   // hang guard, well above the expected run length
   always @(posedge i_clk)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         error_cnt++;
         finish_test();
      end
   end
   task automatic chk(string nm, logic [7:0] got, logic [7:0] exp);
      n_checks++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("ERROR %s expected %h seen %h", nm, exp, got);
      end
   endtask
   // two idle edges after release before the first request
   task automatic do_reset();
      i_rst_n = 0;
      repeat (12) @(negedge i_clk);
      i_rst_n = 1;
      repeat (2) @(negedge i_clk);
   endtask
   task automatic wr(logic [7:0] a, logic [7:0] d);
      @(negedge i_clk);
      i_index = a;
      i_wdata = d;
      i_wr = 1;
      @(negedge i_clk);
      i_wr = 0;
   endtask
   // read data is combinational, held across one rising edge
   task automatic rd(logic [7:0] a, logic [7:0] e, string nm);
      @(negedge i_clk);
      i_index = a;
      i_rd = 1;
      #1 chk(nm, o_rdata, e);
      @(negedge i_clk);
      i_rd = 0;
   endtask
   task automatic t_regs();
      rd(8'h06, 8'h00, "pwr rst");
      rd(8'h07, 8'h01, "opt rst");
      chk("clk rst", {o_func_clk_div2, o_fast_rate_ok, o_disk_clk_div2}, 5);
      wr(8'h08, 8'h00);
      rd(8'h08, `PCR_DEV_ID_VALUE, "id");
      rd(8'h09, 8'h00, "unmapped");
      i_timeout_irq = 1;
      wr(8'h07, 8'hff);
      rd(8'h07, 8'h9f, "opt wr");
      chk("irq on", o_timeout_irq, 1);
      chk("clk", {o_func_clk_div2, o_fast_rate_ok, o_disk_clk_div2}, 6);
      i_disk_idle = 1;
      i_disk_powered_down = 1;
      wr(8'h07, 8'h00);
      rd(8'h07, 8'h60, "opt stat");
      chk("irq off", o_timeout_irq, 0);
      chk("clk off", {o_func_clk_div2, o_fast_rate_ok, o_disk_clk_div2}, 0);
   endtask
   task automatic t_pins();
      wr(8'h06, 8'h10);
      chk("pins idle", {o_shared_pin_a, o_shared_pin_b}, 3);
      wr(8'h07, 8'h80);
      rd(8'h07, 8'he0, "mask rd");
      chk("pin masked", o_shared_pin_a, 0);
      wr(8'h06, 8'h00);
      chk("pins motor", {o_shared_pin_a, o_shared_pin_b}, 2);
      chk("disk on", {o_disk_oe_n, o_disk_clk_run}, 0);
      chk("disk in", o_disk_in, 8'h3c);
      i_disk_change_in = 1;
      wr(8'h06, 8'h02);
      chk("disk off", {o_disk_oe_n, o_disk_change}, 3);
      chk("disk blocked", o_disk_in, 8'h00);
      wr(8'h06, 8'h00);
      i_disk_change_in = 0;
      i_disk_idle = 0;
      i_disk_powered_down = 0;
   endtask
   task automatic t_gate();
      i_drive_enabled = 0;
      i_serial1_powered_down = 1;
      i_parallel_enabled = 0;
      chk("no float", {o_drive_cs_oe_n, o_serial_oe_n, o_parallel_oe_n,
         o_serial_in[0]}, 0);
      chk("dma off", {o_dma_configurable, o_parallel_dma_ack,
         o_parallel_dma_req_oe_n}, 3);
      // reserved bit 7 written back as read, zero
      wr(8'h06, 8'h4d);
      rd(8'h06, 8'h4d, "reserved");
      chk("drive", {o_drive_cs_oe_n, o_drive_data_bit7}, 2);
      chk("serial", {o_serial_oe_n, o_serial_in[0], o_cts[0], o_dsr[0],
         o_carrier_detect[0], o_ring_indicator[0]}, 8'h3f);
      chk("par", {o_parallel_oe_n, o_busy, o_paper_end, o_printer_select,
         o_ack, o_error}, 8'h33);
      chk("dma on", {o_dma_configurable, o_parallel_dma_ack}, 2);
      i_drive_enabled = 1;
      i_serial1_powered_down = 0;
      i_parallel_enabled = 1;
   endtask
   // a new divisor applies to the running period at once, so skip three ticks first
   task automatic t_baud(logic [7:0] opt, int p, int exp);
      int n;
      wr(8'h07, opt);
      repeat (3) @(posedge o_baud_tick[p]);
      @(negedge i_clk);
      n = 0;
      repeat (40)
      begin
         @(negedge i_clk);
         n++;
         if (o_baud_tick[p])
            break;
      end
      chk("baud", n[7:0], exp[7:0]);
   endtask
   task automatic t_settle();
      int n;
      i_chip_powerdown = 1;
      i_osc_stop_req = 1;
      @(negedge i_clk);
      chk("stopped", {o_osc_run, o_serial_clk_run, o_ecp_clk_run}, 0);
      i_chip_powerdown = 0;
      i_osc_stop_req = 0;
      #1 chk("mreq wake", o_disk_master_req, 0);
      n = 0;
      repeat (40)
      begin
         @(negedge i_clk);
         if (!o_settling)
            break;
         n++;
         chk("mreq held", o_disk_master_req, 0);
      end
      chk("settle", n[7:0], 8'd20);
      chk("mreq free", o_disk_master_req, 1);
   endtask
   task automatic t_lock();
      wr(8'h07, 8'h01);
      wr(8'h06, 8'h20);
      chk("lock", o_lock_active, 1);
      wr(8'h07, 8'h1e);
      rd(8'h07, 8'h1f, "locked opt");
      wr(8'h06, 8'h41);
      rd(8'h06, 8'h61, "locked pwr");
      i_clock_double_strap = 0;
      do_reset();
      rd(8'h06, 8'h00, "unlocked");
      rd(8'h07, 8'h00, "strap low");
   endtask
   // main sequence
   initial
   begin
      do_reset();
      t_regs();
      t_pins();
      t_gate();
      do_reset();
      t_baud(8'h00, 0, 13);
      t_baud(8'h08, 0, 12);
      t_baud(8'h08, 1, 13);
      t_baud(8'h10, 1, 12);
      t_settle();
      t_lock();
      finish_test();
   end
endmodule
bind pcr_power_regs pcr_regs_checker chk_i (.*);
